// >>> verilog/ctmr_timers.sv
// Summary of operation
// - timer 1 overflow sets its flag; interrupt vectoring clears it
// - timer 1 counts only while its run bit is set
// - timer 0 overflow sets its flag; interrupt vectoring clears it
// - timer 0 counts only while its run bit is set, except its split-mode high byte, which runs on timer 1's
// - ext irq b flag: edge or low level; vector clears only in edge mode
// - ext irq a flag: edge or low level; vector clears only in edge mode
// - irq b select one means falling edge, zero means low level
// - irq a select one means falling edge, zero means low level
// - timer 2 overflow sets its flag unless it drives baud; software clears
// - trigger pin falling edge with enable sets trigger flag; software clears
// - receive baud tick from timer 2 when selected, else timer 1
// - transmit baud tick from timer 2 when selected, else timer 1
// - enabled trigger edge captures or reloads unless timer 2 drives baud
// - timer 2 counts only while its run bit is set
// - timer 2 counts count-pin edges or core clocks, as selected
// - capture select picks capture or reload; baud forces overflow reload
// - every count byte is a readable, writable register reset to zero
// - timer 2 reload/capture byte pair holds reload value and captured count
// - gating bit makes counting also need its interrupt pin high
// - timers 0/1 modes: prescaled, cascade, reload, stop or split
`timescale 1ns/10ps
module ctmr_timers (
  input  wire logic       core_clk,                 // core clock
  input  wire logic       srst,                     // synchronous reset
  input  wire logic [7:0] sfr_addr,                 // register address
  input  wire logic       sfr_wr,                   // write strobe
  input  wire logic [7:0] sfr_wdata,                // write data
  input  wire logic       sfr_rd,                   // read strobe
  output logic      [7:0] sfr_rdata,                // read data, next cycle
  input  wire logic [7:0] timer_mode_cfg,           // mode register contents
  input  wire logic       ext_irq_a_pin,            // external interrupt a
  input  wire logic       ext_irq_b_pin,            // external interrupt b
  input  wire logic       timer0_count_pin,         // timer 0 event input
  input  wire logic       timer1_count_pin,         // timer 1 event input
  input  wire logic       third_timer_count_pin,    // timer 2 event input
  input  wire logic       third_timer_trigger_pin,  // timer 2 trigger input
  input  wire logic       vec_timer0,               // vectoring to timer 0 isr
  input  wire logic       vec_timer1,               // vectoring to timer 1 isr
  input  wire logic       vec_ext_a,                // vectoring to ext a isr
  input  wire logic       vec_ext_b,                // vectoring to ext b isr
  output logic            first_timer_overflow_flag,  // timer 0 flag
  output logic            second_timer_overflow_flag, // timer 1 flag
  output logic            ext_irq_a_flag,           // ext a flag
  output logic            ext_irq_b_flag,           // ext b flag
  output logic            third_timer_overflow_flag,  // timer 2 flag
  output logic            third_timer_trigger_flag, // timer 2 trigger flag
  output logic            rx_baud_tick,             // receive baud pulse
  output logic            tx_baud_tick              // transmit baud pulse
);
  logic [7:0]  ctrl_q;
  logic [7:0]  ctrl_d;
  logic [7:0]  t2ctrl_q;
  logic [7:0]  t2ctrl_d;
  logic [7:0]  t0_lo_q;
  logic [7:0]  t0_hi_q;
  logic [7:0]  t1_lo_q;
  logic [7:0]  t1_hi_q;
  logic [15:0] t2_cnt_q;
  logic [15:0] t2_rc_q;
  logic [7:0]  rdata_q;
  logic        rx_tick_q;
  logic        tx_tick_q;
  logic        pa_q;
  logic        pb_q;
  logic        p0_q;
  logic        p1_q;
  logic        p2_q;
  logic        ptr_q;
  logic [16:0] s0;
  logic [16:0] s1;
  logic [1:0]  mode0;
  logic [1:0]  mode1;
  logic        inc0;
  logic        inc1;
  logic        split_hi_inc;
  logic        ovf0;
  logic        ovf1;
  logic        ovf1_own;
  logic        baud;
  logic        inc2;
  logic        ovf2;
  logic        trig;
  logic        reload2;
  logic        capture2;
  logic        w_ctrl;
  logic        w_t2ctrl;

  // one step of timer 0 or 1: {overflow, high, low}
  function automatic logic [16:0] tmr_step(input logic [1:0] m, input logic [7:0] hi,
                                           input logic [7:0] lo, input logic en);
    logic [16:0] r;
    r = {1'b0, hi, lo};
    if (en) begin
      unique case (m)
        ctmr_pkg::MODE_PRESCALED: begin
          r[4:0] = lo[4:0] + 5'h01;
          if (lo[4:0] == 5'h1F) begin
            r[15:8] = hi + 8'h01;
            r[16]   = (hi == 8'hFF);
          end
        end
        ctmr_pkg::MODE_CASCADE: begin
          r[15:0] = {hi, lo} + 16'h0001;
          r[16]   = ({hi, lo} == 16'hFFFF);
        end
        ctmr_pkg::MODE_RELOAD: begin
          r[7:0] = (lo == 8'hFF) ? hi : lo + 8'h01;
          r[16]  = (lo == 8'hFF);
        end
        ctmr_pkg::MODE_SPLIT: begin
          r[7:0] = lo + 8'h01;
          r[16]  = (lo == 8'hFF);
        end
      endcase
    end
    return r;
  endfunction

  assign w_ctrl   = sfr_wr && (sfr_addr == ctmr_pkg::ADDR_TMR_CTRL);
  assign w_t2ctrl = sfr_wr && (sfr_addr == ctmr_pkg::ADDR_T2_CTRL);
  assign mode0    = timer_mode_cfg[ctmr_pkg::B_T0_MODE +: 2];
  assign mode1    = timer_mode_cfg[ctmr_pkg::B_T1_MODE +: 2];

  // counting enables: run bit, optional pin gating, clock or pin edge
  always_comb begin
    inc0 = ctrl_q[ctmr_pkg::B_T0_RUN]
           && (!timer_mode_cfg[ctmr_pkg::B_T0_GATE] || ext_irq_a_pin)
           && (!timer_mode_cfg[ctmr_pkg::B_T0_CSEL] || (p0_q && !timer0_count_pin));
    inc1 = ctrl_q[ctmr_pkg::B_T1_RUN]
           && (!timer_mode_cfg[ctmr_pkg::B_T1_GATE] || ext_irq_b_pin)
           && (!timer_mode_cfg[ctmr_pkg::B_T1_CSEL] || (p1_q && !timer1_count_pin))
           && (mode1 != ctmr_pkg::MODE_SPLIT);
    split_hi_inc = (mode0 == ctmr_pkg::MODE_SPLIT) && ctrl_q[ctmr_pkg::B_T1_RUN];
  end

  assign s0       = tmr_step(mode0, t0_hi_q, t0_lo_q, inc0);
  assign s1       = tmr_step(mode1, t1_hi_q, t1_lo_q, inc1);
  assign ovf0     = s0[16];
  assign ovf1_own = s1[16];
  assign ovf1     = (mode0 == ctmr_pkg::MODE_SPLIT) ? (split_hi_inc && t0_hi_q == 8'hFF)
                                                     : ovf1_own;

  // timer 2 events
  always_comb begin
    baud     = t2ctrl_q[ctmr_pkg::B_RX_BAUD] || t2ctrl_q[ctmr_pkg::B_TX_BAUD];
    inc2     = t2ctrl_q[ctmr_pkg::B_T2_RUN]
               && (!t2ctrl_q[ctmr_pkg::B_T2_CSEL]
                   || (p2_q && !third_timer_count_pin));
    ovf2     = inc2 && (t2_cnt_q == 16'hFFFF);
    trig     = t2ctrl_q[ctmr_pkg::B_T2_TREN] && ptr_q && !third_timer_trigger_pin;
    reload2  = (ovf2 && (baud || !t2ctrl_q[ctmr_pkg::B_T2_CAPT]))
               || (trig && !baud && !t2ctrl_q[ctmr_pkg::B_T2_CAPT]);
    capture2 = trig && !baud && t2ctrl_q[ctmr_pkg::B_T2_CAPT];
  end

  // pin history for falling-edge detection
  always_ff @(posedge core_clk) begin
    if (srst) begin
      pa_q  <= 1'b1;
      pb_q  <= 1'b1;
      p0_q  <= 1'b1;
      p1_q  <= 1'b1;
      p2_q  <= 1'b1;
      ptr_q <= 1'b1;
    end else begin
      pa_q  <= ext_irq_a_pin;
      pb_q  <= ext_irq_b_pin;
      p0_q  <= timer0_count_pin;
      p1_q  <= timer1_count_pin;
      p2_q  <= third_timer_count_pin;
      ptr_q <= third_timer_trigger_pin;
    end
  end

  // control flags: a hardware set wins over a write or a vector clear
  always_comb begin
    ctrl_d = w_ctrl ? sfr_wdata : ctrl_q;
    if (ovf1) ctrl_d[ctmr_pkg::B_T1_OVF] = 1'b1;
    else if (vec_timer1) ctrl_d[ctmr_pkg::B_T1_OVF] = 1'b0;
    if (ovf0) ctrl_d[ctmr_pkg::B_T0_OVF] = 1'b1;
    else if (vec_timer0) ctrl_d[ctmr_pkg::B_T0_OVF] = 1'b0;
    if (!ctrl_q[ctmr_pkg::B_EXB_EDGE]) ctrl_d[ctmr_pkg::B_EXB_FLAG] = !ext_irq_b_pin;
    else if (pb_q && !ext_irq_b_pin) ctrl_d[ctmr_pkg::B_EXB_FLAG] = 1'b1;
    else if (vec_ext_b) ctrl_d[ctmr_pkg::B_EXB_FLAG] = 1'b0;
    if (!ctrl_q[ctmr_pkg::B_EXA_EDGE]) ctrl_d[ctmr_pkg::B_EXA_FLAG] = !ext_irq_a_pin;
    else if (pa_q && !ext_irq_a_pin) ctrl_d[ctmr_pkg::B_EXA_FLAG] = 1'b1;
    else if (vec_ext_a) ctrl_d[ctmr_pkg::B_EXA_FLAG] = 1'b0;
    t2ctrl_d = w_t2ctrl ? sfr_wdata : t2ctrl_q;
    if (ovf2 && !baud) t2ctrl_d[ctmr_pkg::B_T2_OVF] = 1'b1;
    if (trig) t2ctrl_d[ctmr_pkg::B_T2_TRIG] = 1'b1;
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      ctrl_q   <= ctmr_pkg::RST_BYTE;
      t2ctrl_q <= ctmr_pkg::RST_BYTE;
    end else begin
      ctrl_q   <= ctrl_d;
      t2ctrl_q <= t2ctrl_d;
    end
  end

  // timer 0 and timer 1 count bytes; a write wins over counting
  always_ff @(posedge core_clk) begin
    if (srst) begin
      t0_lo_q <= ctmr_pkg::RST_BYTE;
      t0_hi_q <= ctmr_pkg::RST_BYTE;
      t1_lo_q <= ctmr_pkg::RST_BYTE;
      t1_hi_q <= ctmr_pkg::RST_BYTE;
    end else begin
      t0_lo_q <= (sfr_wr && sfr_addr == ctmr_pkg::ADDR_T0_LOW) ? sfr_wdata : s0[7:0];
      if (sfr_wr && sfr_addr == ctmr_pkg::ADDR_T0_HIGH) t0_hi_q <= sfr_wdata;
      else if (mode0 == ctmr_pkg::MODE_SPLIT) t0_hi_q <= t0_hi_q + {7'h00, split_hi_inc};
      else t0_hi_q <= s0[15:8];
      t1_lo_q <= (sfr_wr && sfr_addr == ctmr_pkg::ADDR_T1_LOW) ? sfr_wdata : s1[7:0];
      t1_hi_q <= (sfr_wr && sfr_addr == ctmr_pkg::ADDR_T1_HIGH) ? sfr_wdata : s1[15:8];
    end
  end

  // timer 2 count and reload/capture pair
  always_ff @(posedge core_clk) begin
    if (srst) begin
      t2_cnt_q <= {ctmr_pkg::RST_BYTE, ctmr_pkg::RST_BYTE};
      t2_rc_q  <= {ctmr_pkg::RST_BYTE, ctmr_pkg::RST_BYTE};
    end else begin
      if (reload2) t2_cnt_q <= t2_rc_q;
      else if (inc2) t2_cnt_q <= t2_cnt_q + 16'h0001;
      if (sfr_wr && sfr_addr == ctmr_pkg::ADDR_T2_LOW) t2_cnt_q[7:0] <= sfr_wdata;
      if (sfr_wr && sfr_addr == ctmr_pkg::ADDR_T2_HIGH) t2_cnt_q[15:8] <= sfr_wdata;
      if (capture2) t2_rc_q <= t2_cnt_q;
      if (sfr_wr && sfr_addr == ctmr_pkg::ADDR_T2_RC_LOW) t2_rc_q[7:0] <= sfr_wdata;
      if (sfr_wr && sfr_addr == ctmr_pkg::ADDR_T2_RC_HI) t2_rc_q[15:8] <= sfr_wdata;
    end
  end

  // baud pulses to the serial port
  always_ff @(posedge core_clk) begin
    if (srst) begin
      rx_tick_q <= 1'b0;
      tx_tick_q <= 1'b0;
    end else begin
      rx_tick_q <= t2ctrl_q[ctmr_pkg::B_RX_BAUD] ? ovf2 : ovf1_own;
      tx_tick_q <= t2ctrl_q[ctmr_pkg::B_TX_BAUD] ? ovf2 : ovf1_own;
    end
  end

  // read port; unmapped addresses read zero
  always_ff @(posedge core_clk) begin
    if (srst) begin
      rdata_q <= ctmr_pkg::RST_BYTE;
    end else if (sfr_rd) begin
      unique case (sfr_addr)
        ctmr_pkg::ADDR_TMR_CTRL:  rdata_q <= ctrl_q;
        ctmr_pkg::ADDR_T0_LOW:    rdata_q <= t0_lo_q;
        ctmr_pkg::ADDR_T1_LOW:    rdata_q <= t1_lo_q;
        ctmr_pkg::ADDR_T0_HIGH:   rdata_q <= t0_hi_q;
        ctmr_pkg::ADDR_T1_HIGH:   rdata_q <= t1_hi_q;
        ctmr_pkg::ADDR_T2_CTRL:   rdata_q <= t2ctrl_q;
        ctmr_pkg::ADDR_T2_RC_LOW: rdata_q <= t2_rc_q[7:0];
        ctmr_pkg::ADDR_T2_RC_HI:  rdata_q <= t2_rc_q[15:8];
        ctmr_pkg::ADDR_T2_LOW:    rdata_q <= t2_cnt_q[7:0];
        ctmr_pkg::ADDR_T2_HIGH:   rdata_q <= t2_cnt_q[15:8];
        default:                  rdata_q <= ctmr_pkg::RST_BYTE;
      endcase
    end
  end

  assign sfr_rdata                  = rdata_q;
  assign first_timer_overflow_flag  = ctrl_q[ctmr_pkg::B_T0_OVF];
  assign second_timer_overflow_flag = ctrl_q[ctmr_pkg::B_T1_OVF];
  assign ext_irq_a_flag             = ctrl_q[ctmr_pkg::B_EXA_FLAG];
  assign ext_irq_b_flag             = ctrl_q[ctmr_pkg::B_EXB_FLAG];
  assign third_timer_overflow_flag  = t2ctrl_q[ctmr_pkg::B_T2_OVF];
  assign third_timer_trigger_flag   = t2ctrl_q[ctmr_pkg::B_T2_TRIG];
  assign rx_baud_tick               = rx_tick_q;
  assign tx_baud_tick               = tx_tick_q;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  sequence seq_rx_from_t2;
    t2ctrl_q[ctmr_pkg::B_RX_BAUD] && ovf2 ##1 rx_baud_tick;
  endsequence
  sequence seq_tx_from_t1;
    !t2ctrl_q[ctmr_pkg::B_TX_BAUD] && ovf1_own ##1 tx_baud_tick;
  endsequence

  a_t1_ovf_set:
    assert property (ovf1 |=> second_timer_overflow_flag)
      else $error("timer 1 overflow did not set its flag");
  a_t1_vec_clear:
    assert property (vec_timer1 && !ovf1 && !w_ctrl |=> !second_timer_overflow_flag)
      else $error("timer 1 flag not cleared on vector");
  a_t0_ovf_set:
    assert property (ovf0 |=> first_timer_overflow_flag)
      else $error("timer 0 overflow did not set its flag");
  a_t0_run_hold:
    assert property (!ctrl_q[ctmr_pkg::B_T0_RUN] && !(sfr_wr && sfr_addr == ctmr_pkg::ADDR_T0_LOW)
                     |=> $stable(t0_lo_q))
      else $error("timer 0 low byte moved while stopped");
  a_t1_run_hold:
    assert property (!ctrl_q[ctmr_pkg::B_T1_RUN]
                     && !(sfr_wr && sfr_addr == ctmr_pkg::ADDR_T1_HIGH)
                     && !(sfr_wr && sfr_addr == ctmr_pkg::ADDR_T1_LOW)
                     |=> $stable(t1_lo_q) && $stable(t1_hi_q))
      else $error("timer 1 moved while stopped");
  a_exa_edge_set:
    assert property (ctrl_q[ctmr_pkg::B_EXA_EDGE] && !w_ctrl && pa_q && !ext_irq_a_pin
                     |=> ext_irq_a_flag)
      else $error("ext a falling edge missed");
  a_exb_level_follow:
    assert property (!ctrl_q[ctmr_pkg::B_EXB_EDGE] && !w_ctrl
                     |=> ext_irq_b_flag == !$past(ext_irq_b_pin))
      else $error("ext b flag does not follow the low level");
  a_t2_baud_noflag:
    assert property (baud && !third_timer_overflow_flag && !w_t2ctrl
                     |=> !third_timer_overflow_flag)
      else $error("timer 2 flag set while clocking the serial port");
  a_t2_trig_flag:
    assert property (trig |=> third_timer_trigger_flag)
      else $error("trigger edge did not set the trigger flag");
  a_t2_capture_val:
    assert property (capture2 && !(sfr_wr && sfr_addr[7:1] == 7'h65)
                     |=> t2_rc_q == $past(t2_cnt_q))
      else $error("capture did not load the count");
  a_t2_clock_step:
    assert property (t2ctrl_q[ctmr_pkg::B_T2_RUN] && !t2ctrl_q[ctmr_pkg::B_T2_CSEL] && !reload2
                     && !(sfr_wr && sfr_addr[7:1] == 7'h66) |=> t2_cnt_q == $past(t2_cnt_q) + 16'h0001)
      else $error("timer 2 did not step on the core clock");
  a_rx_baud_src:
    assert property (seq_rx_from_t2 or !(t2ctrl_q[ctmr_pkg::B_RX_BAUD] && ovf2))
      else $error("receive baud pulse missing from timer 2");
  a_tx_baud_src:
    assert property (seq_tx_from_t1 or !(!t2ctrl_q[ctmr_pkg::B_TX_BAUD] && ovf1_own))
      else $error("transmit baud pulse missing from timer 1");
  a_t2_reload_val:
    assert property (reload2 && !(sfr_wr && sfr_addr[7:1] == 7'h66)
                     |=> t2_cnt_q == $past(t2_rc_q))
      else $error("reload did not load the reload value");
  a_exb_vec_clear:
    assert property (ctrl_q[ctmr_pkg::B_EXB_EDGE] && vec_ext_b && !w_ctrl
                     && !(pb_q && !ext_irq_b_pin) |=> !ext_irq_b_flag)
      else $error("ext b edge flag not cleared on vector");
endmodule // ctmr_timers

// >>> inc/ctmr_pkg.sv
package ctmr_pkg;
  // register addresses
  localparam logic [7:0] ADDR_TMR_CTRL  = 8'h88;
  localparam logic [7:0] ADDR_T0_LOW    = 8'h8A;
  localparam logic [7:0] ADDR_T1_LOW    = 8'h8B;
  localparam logic [7:0] ADDR_T0_HIGH   = 8'h8C;
  localparam logic [7:0] ADDR_T1_HIGH   = 8'h8D;
  localparam logic [7:0] ADDR_T2_CTRL   = 8'hC8;
  localparam logic [7:0] ADDR_T2_RC_LOW = 8'hCA;
  localparam logic [7:0] ADDR_T2_RC_HI  = 8'hCB;
  localparam logic [7:0] ADDR_T2_LOW    = 8'hCC;
  localparam logic [7:0] ADDR_T2_HIGH   = 8'hCD;
  // timer and external interrupt control fields
  localparam int B_T1_OVF   = 7;
  localparam int B_T1_RUN   = 6;
  localparam int B_T0_OVF   = 5;
  localparam int B_T0_RUN   = 4;
  localparam int B_EXB_FLAG = 3;
  localparam int B_EXB_EDGE = 2;
  localparam int B_EXA_FLAG = 1;
  localparam int B_EXA_EDGE = 0;
  // timer 2 control fields
  localparam int B_T2_OVF   = 7;
  localparam int B_T2_TRIG  = 6;
  localparam int B_RX_BAUD  = 5;
  localparam int B_TX_BAUD  = 4;
  localparam int B_T2_TREN  = 3;
  localparam int B_T2_RUN   = 2;
  localparam int B_T2_CSEL  = 1;
  localparam int B_T2_CAPT  = 0;
  // mode configuration input fields
  localparam int B_T1_GATE  = 7;
  localparam int B_T1_CSEL  = 6;
  localparam int B_T1_MODE  = 4;
  localparam int B_T0_GATE  = 3;
  localparam int B_T0_CSEL  = 2;
  localparam int B_T0_MODE  = 0;
  // counting modes of timers 0 and 1
  localparam logic [1:0] MODE_PRESCALED = 2'h0;
  localparam logic [1:0] MODE_CASCADE   = 2'h1;
  localparam logic [1:0] MODE_RELOAD    = 2'h2;
  localparam logic [1:0] MODE_SPLIT     = 2'h3;
  localparam logic [7:0] RST_BYTE       = 8'h00;
endpackage : ctmr_pkg

// >>> sim/ctmr_irq_ctrl_model.sv
`timescale 1ns/10ps
module ctmr_irq_ctrl_model (
  input  wire logic       core_clk,   // core clock
  input  wire logic       srst,       // synchronous reset
  input  wire logic [3:0] irq_en,     // sources serviced: ext b, ext a, timer 1, timer 0
  input  wire logic [3:0] vec_delay,  // cycles from request to vectoring
  input  wire logic [3:0] flags,      // request flags, same order
  output logic      [3:0] vec         // one-cycle vectoring pulses
);
  logic [3:0] wait_q [4];

  // vectors again after each delay while a flag stays up, as a busy core would
  always @(negedge core_clk) begin
    for (int i = 0; i < 4; i++) begin
      vec[i] <= 1'b0;
      if (srst || !flags[i] || !irq_en[i]) begin
        wait_q[i] <= 4'h0;
      end else if (wait_q[i] == vec_delay) begin
        vec[i]    <= 1'b1;
        wait_q[i] <= 4'h0;
      end else begin
        wait_q[i] <= wait_q[i] + 4'h1;
      end
    end
  end
endmodule // ctmr_irq_ctrl_model

// >>> sim/ctmr_timers_tb_top.sv
`timescale 1ns/10ps
module ctmr_timers_tb_top;
  logic       core_clk, srst, sfr_wr, sfr_rd, t0f, t1f, exa_f, exb_f, t2f, t2x;
  logic       ext_irq_a_pin, ext_irq_b_pin, timer0_count_pin, timer1_count_pin;
  logic       third_timer_count_pin, third_timer_trigger_pin, rx_tick, tx_tick;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, timer_mode_cfg, d0, d1;
  logic [3:0] vec, irq_en, vec_delay;
  int         bad_count, comparisons, rxn, txn;
  logic [7:0] amap [11] = '{ctmr_pkg::ADDR_TMR_CTRL, ctmr_pkg::ADDR_T0_LOW,
    ctmr_pkg::ADDR_T1_LOW, ctmr_pkg::ADDR_T0_HIGH, ctmr_pkg::ADDR_T1_HIGH,
    ctmr_pkg::ADDR_T2_RC_LOW, ctmr_pkg::ADDR_T2_RC_HI, ctmr_pkg::ADDR_T2_LOW,
    ctmr_pkg::ADDR_T2_HIGH, ctmr_pkg::ADDR_T2_CTRL, 8'h80};

  ctmr_timers DUT (.core_clk(core_clk), .srst(srst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
    .timer_mode_cfg(timer_mode_cfg), .ext_irq_a_pin(ext_irq_a_pin),
    .ext_irq_b_pin(ext_irq_b_pin), .timer0_count_pin(timer0_count_pin),
    .timer1_count_pin(timer1_count_pin), .third_timer_count_pin(third_timer_count_pin),
    .third_timer_trigger_pin(third_timer_trigger_pin), .vec_timer0(vec[0]),
    .vec_timer1(vec[1]), .vec_ext_a(vec[2]), .vec_ext_b(vec[3]),
    .first_timer_overflow_flag(t0f), .second_timer_overflow_flag(t1f),
    .ext_irq_a_flag(exa_f), .ext_irq_b_flag(exb_f), .third_timer_overflow_flag(t2f),
    .third_timer_trigger_flag(t2x), .rx_baud_tick(rx_tick), .tx_baud_tick(tx_tick));

  ctmr_irq_ctrl_model irq_ctrl (.core_clk(core_clk), .srst(srst), .irq_en(irq_en),
    .vec_delay(vec_delay), .flags({exb_f, exa_f, t1f, t0f}), .vec(vec));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH at %0t: seen 0x%h expected 0x%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    sfr_wr = 1'b1;
    sfr_addr = a;
    sfr_wdata = d;
    @(posedge core_clk);
    @(negedge core_clk);
    sfr_wr = 1'b0;
  endtask

  // two reads on consecutive edges
  task automatic rd2(input logic [7:0] a, input logic [7:0] b, output logic [7:0] da,
                     output logic [7:0] db);
    @(negedge core_clk);
    sfr_rd = 1'b1;
    sfr_addr = a;
    @(posedge core_clk);
    @(negedge core_clk);
    sfr_addr = b;
    da = sfr_rdata;
    @(posedge core_clk);
    @(negedge core_clk);
    sfr_rd = 1'b0;
    db = sfr_rdata;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] x, y;
    rd2(a, a, x, y);
    chk(x, exp);
  endtask

  function automatic logic sig(input int s);
    case (s)
      0: return t0f;
      1: return t1f;
      2: return exa_f;
      3: return exb_f;
      default: return t2f;
    endcase
  endfunction

  task automatic wait_sig(input int s, input logic lvl, input int lim);
    int k;
    k = 0;
    while (sig(s) !== lvl && k < lim) begin
      @(negedge core_clk);
      k++;
    end
    chk({7'h0, sig(s)}, {7'h0, lvl});
  endtask

  task automatic count_ticks(input int k);
    rxn = 0;
    txn = 0;
    repeat (k) begin
      @(negedge core_clk);
      rxn += int'(rx_tick === 1'b1);
      txn += int'(tx_tick === 1'b1);
    end
  endtask

  task automatic trig_edge();
    @(negedge core_clk);
    third_timer_trigger_pin = 1'b0;
    repeat (3) @(negedge core_clk);
    third_timer_trigger_pin = 1'b1;
    repeat (2) @(negedge core_clk);
  endtask

  task automatic set_pin(input int j, input logic v);
    if (j == 0) ext_irq_a_pin = v;
    else ext_irq_b_pin = v;
  endtask

  initial begin
    #100000;
    bad_count++;
    give_verdict();
  end

  initial begin
    srst = 1'b1;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    timer_mode_cfg = 8'h00;
    ext_irq_a_pin = 1'b1;
    ext_irq_b_pin = 1'b1;
    timer0_count_pin = 1'b1;
    timer1_count_pin = 1'b1;
    third_timer_count_pin = 1'b1;
    third_timer_trigger_pin = 1'b1;
    irq_en = 4'h0;
    vec_delay = 4'h0;
    bad_count = 0;
    comparisons = 0;
    repeat (20) @(negedge core_clk);
    srst = 1'b0;
    for (int i = 0; i < 11; i++) rdchk(amap[i], 8'h00);
    for (int i = 1; i < 9; i++) begin
      wr(amap[i], 8'h5A ^ 8'(i));
      rdchk(amap[i], 8'h5A ^ 8'(i));
    end
    wr(8'h80, 8'hFF);
    rdchk(8'h80, 8'h00);
    // timer 0, 16-bit mode, serviced promptly
    timer_mode_cfg = 8'h01;
    wr(ctmr_pkg::ADDR_T0_HIGH, 8'hFF);
    wr(ctmr_pkg::ADDR_T0_LOW, 8'hF0);
    irq_en = 4'h1;
    wr(ctmr_pkg::ADDR_TMR_CTRL, 8'h10);
    rd2(ctmr_pkg::ADDR_T0_LOW, ctmr_pkg::ADDR_T0_LOW, d0, d1);
    chk(d1 - d0, 8'h01);
    wait_sig(0, 1'b1, 20);
    wait_sig(0, 1'b0, 10);
    wr(ctmr_pkg::ADDR_TMR_CTRL, 8'h00);
    rd2(ctmr_pkg::ADDR_T0_LOW, ctmr_pkg::ADDR_T0_LOW, d0, d1);
    chk(d1 - d0, 8'h00);
    // gating on pin a
    timer_mode_cfg = 8'h09;
    ext_irq_a_pin = 1'b0;
    wr(ctmr_pkg::ADDR_TMR_CTRL, 8'h10);
    rd2(ctmr_pkg::ADDR_T0_LOW, ctmr_pkg::ADDR_T0_LOW, d0, d1);
    chk(d1 - d0, 8'h00);
    ext_irq_a_pin = 1'b1;
    rd2(ctmr_pkg::ADDR_T0_LOW, ctmr_pkg::ADDR_T0_LOW, d0, d1);
    chk(d1 - d0, 8'h01);
    wr(ctmr_pkg::ADDR_TMR_CTRL, 8'h00);
    // prescaled mode: low five bits carry into the high byte
    timer_mode_cfg = 8'h00;
    wr(ctmr_pkg::ADDR_T0_HIGH, 8'hFF);
    wr(ctmr_pkg::ADDR_T0_LOW, 8'hFC);
    wr(ctmr_pkg::ADDR_TMR_CTRL, 8'h10);
    wait_sig(0, 1'b1, 12);
    wr(ctmr_pkg::ADDR_TMR_CTRL, 8'h00);
    // split mode: timer 0 high byte runs on the timer 1 run bit and flag
    timer_mode_cfg = 8'h03;
    wr(ctmr_pkg::ADDR_T0_HIGH, 8'hF8);
    wr(ctmr_pkg::ADDR_TMR_CTRL, 8'h40);
    wait_sig(1, 1'b1, 12);
    wr(ctmr_pkg::ADDR_TMR_CTRL, 8'h00);
    // timer 1 autoreload every 16 cycles clocks both serial directions
    timer_mode_cfg = 8'h20;
    wr(ctmr_pkg::ADDR_T1_HIGH, 8'hF0);
    wr(ctmr_pkg::ADDR_T1_LOW, 8'hF0);
    irq_en = 4'h2;
    wr(ctmr_pkg::ADDR_TMR_CTRL, 8'h40);
    count_ticks(64);
    chk(8'(rxn), 8'h04);
    chk(8'(txn), 8'h04);
    wait_sig(1, 1'b1, 20);
    wait_sig(1, 1'b0, 10);
    wr(ctmr_pkg::ADDR_TMR_CTRL, 8'h00);
    count_ticks(40);
    chk(8'(rxn + txn), 8'h00);
    timer_mode_cfg = 8'h30;
    wr(ctmr_pkg::ADDR_TMR_CTRL, 8'h40);
    count_ticks(40);
    chk(8'(rxn + txn), 8'h00);
    wr(ctmr_pkg::ADDR_TMR_CTRL, 8'h00);
    irq_en = 4'h0;
    // timer 2 as baud source
    wr(ctmr_pkg::ADDR_T2_RC_HI, 8'hFF);
    wr(ctmr_pkg::ADDR_T2_RC_LOW, 8'hF0);
    wr(ctmr_pkg::ADDR_T2_HIGH, 8'hFF);
    wr(ctmr_pkg::ADDR_T2_LOW, 8'hF0);
    wr(ctmr_pkg::ADDR_T2_CTRL, 8'h35);
    count_ticks(64);
    chk(8'(rxn), 8'h04);
    chk(8'(txn), 8'h04);
    chk({7'h0, t2f}, 8'h00);
    // receive from timer 2 only; transmit falls back to the stopped timer 1
    wr(ctmr_pkg::ADDR_T2_CTRL, 8'h25);
    count_ticks(64);
    chk(8'(rxn), 8'h04);
    chk(8'(txn), 8'h00);
    // timer 2 overflow with reload
    wr(ctmr_pkg::ADDR_T2_CTRL, 8'h00);
    wr(ctmr_pkg::ADDR_T2_RC_HI, 8'h55);
    wr(ctmr_pkg::ADDR_T2_LOW, 8'hFE);
    wr(ctmr_pkg::ADDR_T2_CTRL, 8'h04);
    wait_sig(4, 1'b1, 20);
    wr(ctmr_pkg::ADDR_T2_CTRL, 8'h00);
    chk({7'h0, t2f}, 8'h00);
    rdchk(ctmr_pkg::ADDR_T2_HIGH, 8'h55);
    // capture, trigger reload, trigger disabled, on a stopped count
    wr(ctmr_pkg::ADDR_T2_HIGH, 8'h12);
    wr(ctmr_pkg::ADDR_T2_LOW, 8'h34);
    wr(ctmr_pkg::ADDR_T2_CTRL, 8'h09);
    trig_edge();
    chk({7'h0, t2x}, 8'h01);
    rdchk(ctmr_pkg::ADDR_T2_RC_LOW, 8'h34);
    rdchk(ctmr_pkg::ADDR_T2_RC_HI, 8'h12);
    wr(ctmr_pkg::ADDR_T2_CTRL, 8'h09);
    chk({7'h0, t2x}, 8'h00);
    wr(ctmr_pkg::ADDR_T2_LOW, 8'h00);
    wr(ctmr_pkg::ADDR_T2_HIGH, 8'h00);
    wr(ctmr_pkg::ADDR_T2_CTRL, 8'h08);
    trig_edge();
    rdchk(ctmr_pkg::ADDR_T2_LOW, 8'h34);
    rdchk(ctmr_pkg::ADDR_T2_HIGH, 8'h12);
    wr(ctmr_pkg::ADDR_T2_LOW, 8'h77);
    wr(ctmr_pkg::ADDR_T2_CTRL, 8'h00);
    trig_edge();
    rdchk(ctmr_pkg::ADDR_T2_LOW, 8'h77);
    chk({7'h0, t2x}, 8'h00);
    // counter function: five falling edges on the count pin
    wr(ctmr_pkg::ADDR_T2_LOW, 8'h00);
    wr(ctmr_pkg::ADDR_T2_CTRL, 8'h06);
    repeat (5) begin
      @(negedge core_clk);
      third_timer_count_pin = 1'b0;
      repeat (2) @(negedge core_clk);
      third_timer_count_pin = 1'b1;
      repeat (2) @(negedge core_clk);
    end
    wr(ctmr_pkg::ADDR_T2_CTRL, 8'h00);
    rdchk(ctmr_pkg::ADDR_T2_LOW, 8'h05);
    // external pins: edge mode with slow vectoring, then level mode
    vec_delay = 4'h6;
    for (int j = 0; j < 2; j++) begin
      wr(ctmr_pkg::ADDR_TMR_CTRL, 8'h05);
      set_pin(j, 1'b0);
      wait_sig(2 + j, 1'b1, 5);
      set_pin(j, 1'b1);
      repeat (3) @(negedge core_clk);
      chk({7'h0, sig(2 + j)}, 8'h01);
      irq_en = 4'h4 << j;
      wait_sig(2 + j, 1'b0, 12);
      irq_en = 4'h0;
      wr(ctmr_pkg::ADDR_TMR_CTRL, 8'h00);
      set_pin(j, 1'b0);
      wait_sig(2 + j, 1'b1, 5);
      irq_en = 4'h4 << j;
      repeat (12) @(negedge core_clk);
      chk({7'h0, sig(2 + j)}, 8'h01);
      set_pin(j, 1'b1);
      wait_sig(2 + j, 1'b0, 5);
      irq_en = 4'h0;
    end
    give_verdict();
  end
endmodule // ctmr_timers_tb_top
